// file: src/cpu_store16_stop_subtract_exec_regs.vh
// constants for the 16-bit store, stop and subtract executor
`ifndef CPU_STORE16_STOP_SUBTRACT_EXEC_REGS_VH
`define CPU_STORE16_STOP_SUBTRACT_EXEC_REGS_VH

// --------------------------------------------------------------
// condition code bit positions
// --------------------------------------------------------------
`define CC_S 7
`define CC_X 6
`define CC_I 4
`define CC_N 3
`define CC_Z 2
`define CC_V 1
`define CC_C 0

// --------------------------------------------------------------
// reset values
// --------------------------------------------------------------
`define RESET_PC 16'h0000
`define RESET_CCR 8'hd0
`define RESET_WORD 16'h0000
`define RESET_BYTE 8'h00

// --------------------------------------------------------------
// opcodes and fixed addresses
// --------------------------------------------------------------
`define PRE_Y 8'h18
`define PRE_1A 8'h1a
`define PRE_CD 8'hcd
`define OP_STOP 8'hcf
`define LOW_STORE_D 4'hd
`define LOW_STORE_W 4'hf
`define LOW_SUB 4'h0
`define OP_IDX_STORE_W 8'hef
`define IDLE_ADDR 16'hffff
`define ZERO_PAGE 8'h00

// --------------------------------------------------------------
// addressing mode field op[5:4], store source, load select
// --------------------------------------------------------------
`define MODE_IMM 2'h0
`define MODE_DIR 2'h1
`define MODE_IDX 2'h2
`define MODE_EXT 2'h3
`define SRC_D 2'h0
`define SRC_SP 2'h1
`define SRC_X 2'h2
`define SRC_Y 2'h3
`define LD_A 3'h0
`define LD_B 3'h1
`define LD_X 3'h2
`define LD_Y 3'h3
`define LD_SP 3'h4
`define LD_CCR 3'h5

`endif

// file: src/cpu_store16_stop_subtract_exec.v
// cpu core subset: 16-bit stores, stop and 8-bit subtract
`timescale 1ns/10ps
`include "cpu_store16_stop_subtract_exec_regs.vh"

module cpu_store16_stop_subtract_exec (
	input wire i_mclk,
	input wire i_rst_b,
	input wire i_ce,
	input wire [7:0] i_rdata,
	input wire i_nonmaskable_interrupt_pin_b,
	input wire i_irq_request_b,
	input wire i_load,
	input wire [2:0] i_load_sel,
	input wire [15:0] i_load_data,
	output reg [15:0] o_addr,
	output reg [7:0] o_wdata,
	output reg o_rw,
	output reg o_stopped,
	output reg o_int_entry,
	output reg o_int_maskable,
	output reg [7:0] o_acc_a,
	output reg [7:0] o_acc_b,
	output reg [15:0] o_index_x,
	output reg [15:0] o_index_y,
	output reg [15:0] o_stack_pointer,
	output reg [7:0] o_condition_code_register,
	output reg [15:0] o_pc
);

// --------------------------------------------------------------
// states
// --------------------------------------------------------------
localparam [3:0] S_FETCH = 4'h0;
localparam [3:0] S_PREOP = 4'h1;
localparam [3:0] S_INH2 = 4'h2;
localparam [3:0] S_OPND1 = 4'h3;
localparam [3:0] S_OPND2 = 4'h4;
localparam [3:0] S_IDLE = 4'h5;
localparam [3:0] S_WR1 = 4'h6;
localparam [3:0] S_WR2 = 4'h7;
localparam [3:0] S_RDM = 4'h8;
localparam [3:0] S_STOP = 4'h9;

// decode classes
localparam [1:0] K_NOP = 2'h0;
localparam [1:0] K_STORE = 2'h1;
localparam [1:0] K_SUB = 2'h2;
localparam [1:0] K_STOP = 2'h3;

reg [3:0] state;
reg [1:0] kind;
reg [1:0] mode;
reg [1:0] src;
reg acc_b_sel;
reg use_y;
reg [7:0] prefix;
reg [7:0] hi_byte;
reg [15:0] ea;

// --------------------------------------------------------------
// helper functions
// --------------------------------------------------------------
// class of an opcode given its prefix; unknown forms run as no_operation
function [1:0] decode_kind;
	input [7:0] pre;
	input [7:0] op;
	reg none;
	begin
		none = (pre == `RESET_BYTE);
		decode_kind = K_NOP;
		if (none && op == `OP_STOP) begin
			decode_kind = K_STOP;
		end else if (op[7] && op[3:0] == `LOW_STORE_D && op[6]) begin
			if (none || (pre == `PRE_Y && op[5:4] == `MODE_IDX)) begin
				decode_kind = K_STORE;
			end
		end else if (op[7] && op[3:0] == `LOW_STORE_W &&
			op[5:4] != `MODE_IMM) begin
			if (none) begin
				decode_kind = K_STORE;
			end else if (pre == `PRE_Y && (op[6] || op[5:4] == `MODE_IDX)) begin
				decode_kind = K_STORE;
			end else if (op == `OP_IDX_STORE_W &&
				(pre == `PRE_1A || pre == `PRE_CD)) begin
				decode_kind = K_STORE;
			end
		end else if (op[7] && op[3:0] == `LOW_SUB) begin
			if (none || (pre == `PRE_Y && op[5:4] == `MODE_IDX)) begin
				decode_kind = K_SUB;
			end
		end
	end
endfunction

// store source register for a store opcode
function [1:0] decode_src;
	input [7:0] pre;
	input [7:0] op;
	begin
		if (op[3:0] == `LOW_STORE_D) begin
			decode_src = `SRC_D;
		end else if (!op[6]) begin
			decode_src = `SRC_SP;
		end else if (pre == `PRE_Y || pre == `PRE_1A) begin
			decode_src = `SRC_Y;
		end else begin
			decode_src = `SRC_X;
		end
	end
endfunction

// indexed effective address
function [15:0] index_addr;
	input [15:0] base;
	input [7:0] offset;
	begin
		index_addr = base + {`ZERO_PAGE, offset};
	end
endfunction

// 8-bit subtract result with new condition codes
function [15:0] subtract8;
	input [7:0] acc;
	input [7:0] mem;
	input [7:0] cc;
	reg [7:0] r;
	reg [7:0] f;
	begin
		r = acc - mem;
		f = cc;
		f[`CC_N] = r[7];
		f[`CC_Z] = (r == `RESET_BYTE);
		f[`CC_V] = (acc[7] & ~mem[7] & ~r[7]) |
			(~acc[7] & mem[7] & r[7]);
		f[`CC_C] = (mem > acc);
		subtract8 = {r, f};
	end
endfunction

// --------------------------------------------------------------
// datapath helpers
// --------------------------------------------------------------
reg [15:0] src_val;
reg [7:0] sub_acc;
wire [7:0] full_op;
wire [1:0] op_kind;
wire [1:0] op_src;
wire op_prefix;
wire [15:0] sub_res;
wire [7:0] sub_mem;

assign op_prefix = (i_rdata == `PRE_Y) || (i_rdata == `PRE_1A) ||
	(i_rdata == `PRE_CD);
assign full_op = i_rdata;
assign op_kind = decode_kind((state == S_PREOP) ? prefix : `RESET_BYTE,
	full_op);
assign op_src = decode_src((state == S_PREOP) ? prefix : `RESET_BYTE,
	full_op);
assign sub_mem = i_rdata;
assign sub_res = subtract8(sub_acc, sub_mem, o_condition_code_register);

always @* begin
	case (src)
		`SRC_D: src_val = {o_acc_a, o_acc_b};
		`SRC_SP: src_val = o_stack_pointer;
		`SRC_X: src_val = o_index_x;
		default: src_val = o_index_y;
	endcase
	sub_acc = acc_b_sel ? o_acc_b : o_acc_a;
end

// --------------------------------------------------------------
// sequencer
// --------------------------------------------------------------
always @(posedge i_mclk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		state <= S_FETCH;
		kind <= K_NOP;
		mode <= `MODE_IMM;
		src <= `SRC_D;
		acc_b_sel <= 1'b0;
		use_y <= 1'b0;
		prefix <= `RESET_BYTE;
		hi_byte <= `RESET_BYTE;
		ea <= `RESET_WORD;
		o_addr <= `RESET_PC;
		o_wdata <= `RESET_BYTE;
		o_rw <= 1'b1;
		o_stopped <= 1'b0;
		o_int_entry <= 1'b0;
		o_int_maskable <= 1'b0;
		o_acc_a <= `RESET_BYTE;
		o_acc_b <= `RESET_BYTE;
		o_index_x <= `RESET_WORD;
		o_index_y <= `RESET_WORD;
		o_stack_pointer <= `RESET_WORD;
		o_condition_code_register <= `RESET_CCR;
		o_pc <= `RESET_PC;
	end else if (i_ce) begin
		o_int_entry <= 1'b0;
		case (state)
			S_FETCH, S_PREOP: begin
				o_pc <= o_pc + 16'h0001;
				o_addr <= o_pc + 16'h0001;
				if (state == S_FETCH && op_prefix) begin
					prefix <= i_rdata;
					state <= S_PREOP;
				end else begin
					kind <= op_kind;
					mode <= full_op[5:4];
					src <= op_src;
					acc_b_sel <= full_op[6];
					use_y <= (state == S_PREOP) &&
						(prefix == `PRE_Y || prefix == `PRE_CD);
					prefix <= `RESET_BYTE;
					if (op_kind == K_NOP || op_kind == K_STOP) begin
						// single byte: pc already points past it
						state <= S_INH2;
					end else begin
						state <= S_OPND1;
					end
				end
			end
			S_INH2: begin
				if (kind == K_STOP &&
					!o_condition_code_register[`CC_S]) begin
					o_stopped <= 1'b1;
					state <= S_STOP;
				end else begin
					o_addr <= o_pc;
					state <= S_FETCH;
				end
			end
			S_OPND1: begin
				o_pc <= o_pc + 16'h0001;
				hi_byte <= i_rdata;
				case (mode)
					`MODE_IMM: begin
						if (acc_b_sel) begin
							o_acc_b <= sub_res[15:8];
						end else begin
							o_acc_a <= sub_res[15:8];
						end
						o_condition_code_register <= sub_res[7:0];
						o_addr <= o_pc + 16'h0001;
						state <= S_FETCH;
					end
					`MODE_DIR: begin
						ea <= {`ZERO_PAGE, i_rdata};
						o_addr <= {`ZERO_PAGE, i_rdata};
						o_rw <= (kind != K_STORE);
						o_wdata <= src_val[15:8];
						state <= (kind == K_STORE) ? S_WR1 : S_RDM;
					end
					`MODE_IDX: begin
						ea <= index_addr(use_y ? o_index_y : o_index_x,
							i_rdata);
						o_addr <= `IDLE_ADDR;
						state <= S_IDLE;
					end
					default: begin
						o_addr <= o_pc + 16'h0001;
						state <= S_OPND2;
					end
				endcase
			end
			S_OPND2, S_IDLE: begin
				if (state == S_OPND2) begin
					o_pc <= o_pc + 16'h0001;
					ea <= {hi_byte, i_rdata};
					o_addr <= {hi_byte, i_rdata};
				end else begin
					o_addr <= ea;
				end
				o_rw <= (kind != K_STORE);
				o_wdata <= src_val[15:8];
				state <= (kind == K_STORE) ? S_WR1 : S_RDM;
			end
			S_WR1: begin
				o_addr <= ea + 16'h0001;
				o_wdata <= src_val[7:0];
				state <= S_WR2;
			end
			S_WR2: begin
				o_condition_code_register[`CC_N] <= src_val[15];
				o_condition_code_register[`CC_Z] <=
					(src_val == `RESET_WORD);
				o_condition_code_register[`CC_V] <= 1'b0;
				o_rw <= 1'b1;
				o_addr <= o_pc;
				state <= S_FETCH;
			end
			S_RDM: begin
				if (acc_b_sel) begin
					o_acc_b <= sub_res[15:8];
				end else begin
					o_acc_a <= sub_res[15:8];
				end
				o_condition_code_register <= sub_res[7:0];
				o_addr <= o_pc;
				state <= S_FETCH;
			end
			S_STOP: begin
				if (!i_nonmaskable_interrupt_pin_b) begin
					o_stopped <= 1'b0;
					o_addr <= o_pc;
					o_int_entry <=
						!o_condition_code_register[`CC_X];
					o_int_maskable <= 1'b0;
					state <= S_FETCH;
				end else if (!i_irq_request_b &&
					!o_condition_code_register[`CC_I]) begin
					o_stopped <= 1'b0;
					o_addr <= o_pc;
					o_int_entry <= 1'b1;
					o_int_maskable <= 1'b1;
					state <= S_FETCH;
				end
			end
			default: begin
				o_addr <= o_pc;
				o_rw <= 1'b1;
				state <= S_FETCH;
			end
		endcase
		// preset port wins over the instruction in the same cycle
		if (i_load) begin
			case (i_load_sel)
				`LD_A: o_acc_a <= i_load_data[7:0];
				`LD_B: o_acc_b <= i_load_data[7:0];
				`LD_X: o_index_x <= i_load_data;
				`LD_Y: o_index_y <= i_load_data;
				`LD_SP: o_stack_pointer <= i_load_data;
				`LD_CCR: o_condition_code_register <= i_load_data[7:0];
				default: begin
				end
			endcase
		end
	end
end

endmodule

// file: testbench/cpu_store16_stop_subtract_exec_checker.sv
// checker for the 16-bit store, stop and subtract executor
`timescale 1ns/10ps
`include "cpu_store16_stop_subtract_exec_regs.vh"
module cpu_store16_stop_subtract_exec_checker (
	input wire i_mclk,
	input wire i_rst_b,
	input wire i_ce,
	input wire i_nonmaskable_interrupt_pin_b,
	input wire i_irq_request_b,
	input wire [15:0] o_addr,
	input wire [7:0] o_wdata,
	input wire o_rw,
	input wire o_stopped,
	input wire o_int_entry,
	input wire o_int_maskable,
	input wire [7:0] o_condition_code_register,
	input wire [15:0] o_pc
);
	// ----
	// stop and store properties
	// ----
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	wire [7:0] cc = o_condition_code_register;
	wire nmi = !i_nonmaskable_interrupt_pin_b;
	wire irq = !i_irq_request_b && !cc[`CC_I];
	sequence write_pair;
		!o_rw ##1 !o_rw;
	endsequence
	stop_hold_a: assert property (o_stopped && !nmi && !irq |=> o_stopped)
		else $error("stop left early");
	stop_bus_a: assert property (
		o_stopped && $past(o_stopped) |-> o_rw && $stable(o_addr))
		else $error("bus moved in stop");
	nmi_wake_a: assert property (o_stopped && i_ce && nmi |=>
		!o_stopped && o_int_entry == !$past(cc[`CC_X]) && !o_int_maskable)
		else $error("bad nmi wake");
	irq_wake_a: assert property (o_stopped && i_ce && !nmi && irq |=>
		!o_stopped && o_int_entry && o_int_maskable)
		else $error("bad irq wake");
	entry_cause_a: assert property (
		o_int_entry |-> $past(o_stopped) && !o_stopped)
		else $error("entry without stop");
	wake_fetch_a: assert property (
		$fell(o_stopped) |-> o_rw && o_addr == o_pc)
		else $error("no fetch at wake");
	pair_addr_a: assert property (
		write_pair |-> o_addr == $past(o_addr) + 16'h0001)
		else $error("low byte misplaced");
	store_nz_a: assert property (write_pair |=>
		cc[`CC_N] == $past(o_wdata[7], 2) && cc[`CC_Z] ==
		($past(o_wdata, 2) == 8'h00 && $past(o_wdata) == 8'h00))
		else $error("store n or z wrong");
	store_vc_a: assert property (write_pair |=>
		!cc[`CC_V] && cc[`CC_C] == $past(cc[`CC_C], 2))
		else $error("store v or c wrong");
endmodule
bind cpu_store16_stop_subtract_exec cpu_store16_stop_subtract_exec_checker
	chk_u (.i_mclk, .i_rst_b, .i_ce, .i_nonmaskable_interrupt_pin_b,
	.i_irq_request_b, .o_addr, .o_wdata, .o_rw, .o_stopped, .o_int_entry,
	.o_int_maskable, .o_condition_code_register, .o_pc);

// file: testbench/mem_model.sv
// memory model on the far side of the core bus
`timescale 1ns/10ps
module mem_model (
	input wire i_clk,
	input wire i_rst_b,
	input wire [15:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_rw,
	output wire [7:0] o_rdata
);
	// ----
	// storage and write capture
	// ----
	logic [7:0] mem [0:65535];
	logic [15:0] cyc;
	logic [15:0] last_wcyc;
	// core owns the bus on writes, so no stale byte
	assign o_rdata = i_rw ? mem[i_addr] : ~i_wdata;
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cyc <= 16'h0000;
			last_wcyc <= 16'hffff;
		end else begin
			cyc <= cyc + 16'h0001;
			if (!i_rw) begin
				mem[i_addr] <= i_wdata;
				last_wcyc <= cyc;
			end
		end
	end
endmodule

// file: testbench/cpu_store16_stop_subtract_exec_tb.sv
// testbench for the 16-bit store, stop and subtract executor
`timescale 1ns/10ps
`include "cpu_store16_stop_subtract_exec_regs.vh"
module cpu_store16_stop_subtract_exec_tb;
	// ----
	// stimulus, memory and design
	// ----
	logic i_mclk = 1'b0;
	logic i_rst_b = 1'b0;
	logic nmi_b = 1'b1;
	logic irq_b = 1'b1;
	logic ce = 1'b1;
	logic load = 1'b0;
	logic [2:0] load_sel = 3'h0;
	logic [15:0] load_data = 16'h0000;
	wire [15:0] addr, x, y, sp, pc;
	wire [7:0] rdata, wdata, a, b, cc;
	wire rw, stopped, entry, maskable;
	int fail_count = 0;
	int n_tests = 0;
	logic [15:0] ea, v, t;
	logic [7:0] m, acc, r;
	logic [15:0] stores [16] = '{16'h00dd, 16'h00fd, 16'h00ed, 16'h18ed,
		16'h009f, 16'h00bf, 16'h00af, 16'h18af, 16'h00df, 16'h00ff,
		16'h00ef, 16'hcdef, 16'h18df, 16'h18ff, 16'h1aef, 16'h18ef};
	logic [15:0] subs [10] = '{16'h0080, 16'h0090, 16'h00b0, 16'h00a0,
		16'h18a0, 16'h00c0, 16'h00d0, 16'h00f0, 16'h00e0, 16'h18e0};
	// ccr preset, then nmi_b irq_b wake entry maskable
	logic [15:0] stops [5] = '{16'h8f18, 16'h000e, 16'h400c, 16'h0017,
		16'h1010};
	initial forever #25 i_mclk = ~i_mclk;
	mem_model mem_u (.i_clk(i_mclk), .i_rst_b(i_rst_b), .i_addr(addr),
		.i_wdata(wdata), .i_rw(rw), .o_rdata(rdata));
	cpu_store16_stop_subtract_exec dut_u (.i_mclk(i_mclk),
		.i_rst_b(i_rst_b), .i_ce(ce), .i_rdata(rdata),
		.i_nonmaskable_interrupt_pin_b(nmi_b), .i_irq_request_b(irq_b),
		.i_load(load), .i_load_sel(load_sel), .i_load_data(load_data),
		.o_addr(addr), .o_wdata(wdata), .o_rw(rw), .o_stopped(stopped),
		.o_int_entry(entry), .o_int_maskable(maskable), .o_acc_a(a),
		.o_acc_b(b), .o_index_x(x), .o_index_y(y), .o_stack_pointer(sp),
		.o_condition_code_register(cc), .o_pc(pc));
	task check(input [15:0] got, input [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("compares %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// code at 0004 behind four no_operation bytes used for presets
	task run(input [15:0] po, input [7:0] mv, input [15:0] val,
		input [7:0] c);
		logic [15:0] p;
		p = 16'h0004;
		@(posedge i_mclk) i_rst_b <= 1'b0;
		for (int i = 0; i < 65536; i++) mem_u.mem[i] = 8'h00;
		if (po[15:8] != 8'h00) begin
			mem_u.mem[p] = po[15:8];
			p++;
		end
		mem_u.mem[p] = po[7:0];
		case (po[5:4])
			`MODE_IMM: ea = p + 16'h0001;
			`MODE_DIR: ea = 16'h0040;
			`MODE_IDX: ea = val + 16'h0005;
			default: ea = 16'h1234;
		endcase
		mem_u.mem[p + 16'h0001] = po[5:4] == `MODE_IDX ? 8'h05 :
			po[5:4] == `MODE_EXT ? 8'h12 : ea[7:0];
		if (po[5:4] == `MODE_EXT) mem_u.mem[p + 16'h0002] = 8'h34;
		mem_u.mem[ea] = mv;
		repeat (2) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		for (int s = 0; s < 6; s++) begin
			@(posedge i_mclk);
			load <= 1'b1;
			load_sel <= s[2:0];
			load_data <= s == 0 ? {8'h00, val[15:8]} :
				s == 5 ? {8'h00, c} : val;
		end
		@(posedge i_mclk) load <= 1'b0;
		repeat (3) @(posedge i_mclk);
		#1;
	endtask
	initial begin
		#250000;
		fail_count++;
		finish_test;
	end
	initial begin
		repeat (8) @(posedge i_mclk);
		for (int i = 0; i < 5; i++) begin
			t = stops[i];
			run(16'h00cf, 8'h00, 16'h5aa5, t[15:8]);
			check(stopped, !t[15]);
			check(addr, 16'h0005);
			repeat (8) @(posedge i_mclk);
			ce <= 1'b0;
			nmi_b <= t[4];
			irq_b <= t[3];
			repeat (3) @(posedge i_mclk);
			ce <= 1'b1;
			#1 check(stopped, !t[15]);
			@(posedge i_mclk) #1;
			check(stopped, !t[15] && !t[2]);
			check({entry, entry & maskable}, t[1:0]);
			if (t[2]) check(addr, 16'h0005);
			if (!t[15]) check(pc, 16'h0005);
			check(cc, t[15:8]);
			check(x, 16'h5aa5);
			check(y, 16'h5aa5);
			check(sp, 16'h5aa5);
			check({a, b}, 16'h5aa5);
			@(posedge i_mclk);
			nmi_b <= 1'b1;
			irq_b <= 1'b1;
		end
		@(posedge i_mclk) i_rst_b <= 1'b0;
		#1 check(stopped, 16'h0000);
		$display("stop tests done");
		for (int i = 0; i < 16; i++) begin
			v = i == 5 ? 16'h0000 : {i[3:0], 12'h3c6};
			run(stores[i], 8'h00, v, 8'h03);
			repeat (20) @(posedge i_mclk);
			#1;
			t = (stores[i][5:4] == `MODE_DIR ? 16'h000b : 16'h000c)
				+ {15'h0000, stores[i][15:8] != 8'h00};
			check(mem_u.mem[ea], v[15:8]);
			check(mem_u.mem[ea + 16'h0001], v[7:0]);
			check(mem_u.last_wcyc, t);
			check(cc, {4'h0, v[15], v == 16'h0000, 2'b01});
		end
		$display("store tests done");
		for (int i = 0; i < 10; i++) begin
			m = i == 9 ? 8'h20 : 8'h80 + i[7:0] * 8'h13;
			acc = subs[i][6] ? 8'h20 : 8'h7f;
			r = acc - m;
			run(subs[i], m, 16'h7f20, 8'he0);
			repeat (20) @(posedge i_mclk);
			#1;
			check(subs[i][6] ? b : a, r);
			check(cc, {4'he, r[7], r == 8'h00,
				(acc[7] ^ m[7]) & (acc[7] ^ r[7]), m > acc});
		end
		$display("subtract tests done");
		finish_test;
	end
endmodule
